// ===== asi_core.sv
// Serial interface core: rate dividers, transmit FIFO and frame engines
`timescale 1ns/1ps
`include "asi_params.svh"

// ==================================================
// Rate divider for one direction
module asi_rate (
   input wire logic clk,
   input wire logic reset,
   input wire logic pre_tick,
   input wire logic [2:0] div_sel,
   input wire logic [7:0] fine,
   output logic tick
);
   import asi_pkg::*;
   asi_rate_st_t s;
   asi_rate_st_t n;
   logic [6:0] lim;

   // Low div_sel bits set
   assign lim = ~(7'h7f << div_sel);
   assign tick = s.tick;

   // Power-of-two stage, then optional fine stage
   always_comb begin
      n = s;
      n.tick = 1'b0;
      if (pre_tick) begin
         n.div = s.div + 7'h01;
         if (s.div == lim) begin
            n.div = 7'h00;
            n.fn = s.fn + 8'h01;
            // Zero fine value bypasses the stage
            if (fine == 8'h00 || s.fn == fine - 8'h01) begin
               n.fn = 8'h00;
               n.tick = 1'b1;
            end
         end
      end
      if (reset) begin
         n = '0;
      end
   end

   always_ff @(posedge clk) begin
      s <= n;
   end
endmodule

// ==================================================
// Transmit FIFO
module asi_fifo #(
   parameter int W = `ASI_WORD_W,
   parameter int D = `ASI_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic rdy;
   } asi_fifo_st_t;
   asi_fifo_st_t s;
   asi_fifo_st_t n;
   logic push;
   logic pop;

   assign in_ready = s.rdy;
   assign out_valid = (s.cnt != '0);
   assign out_data = s.mem[s.rp];

   // Ready is registered so it can leave the core as a flop
   always_comb begin
      n = s;
      push = in_valid && s.rdy;
      pop = out_ready && (s.cnt != '0);
      if (push) begin
         n.mem[s.wp] = in_data;
         n.wp = s.wp + 1'b1;
      end
      if (pop) begin
         n.rp = s.rp + 1'b1;
      end
      n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
      n.rdy = (n.cnt != (AW+1)'(D));
      if (reset) begin
         n = '0;
         n.rdy = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      s <= n;
   end
endmodule

// ==================================================
// Top: serial transmitter and receiver
module asi_core (
   input wire logic clk,
   input wire logic reset,
   input wire asi_pkg::asi_ctrl_t ctrl,
   input wire asi_pkg::asi_rate_t rate,
   input wire logic tx_ninth_bit,
   input wire logic cpu_irq_mask,
   input wire logic mute_set,
   input wire logic status_access,
   input wire logic data_read,
   input wire logic tx_in_valid,
   input wire logic [7:0] tx_in_data,
   output logic tx_in_ready,
   input wire logic serial_in_pin,
   output logic serial_out_pin,
   output logic serial_out_oe,
   output asi_pkg::asi_stat_t status,
   output logic [7:0] rx_data,
   output logic rx_ninth_bit,
   output logic rx_mute,
   output logic irq
);
   import asi_pkg::*;
   typedef struct packed {
      asi_stat_t st;
      logic armed;
      logic [3:0] pre;
      logic pre_tick;
      asi_txst_t txs;
      asi_kind_t kind;
      logic [10:0] tsh;
      logic [3:0] tbits;
      logic [3:0] tsub;
      logic [7:0] thold;
      logic pend_idle;
      logic brk_sent;
      logic ton_d;
      asi_rxst_t rxs;
      logic [3:0] rsub;
      logic [3:0] rbits;
      logic [8:0] rsh;
      logic smp_a;
      logic smp_b;
      logic nz;
      logic [7:0] idle_cnt;
      logic idle_armed;
      logic [7:0] rbuf;
      logic r9;
      logic mute;
      logic irq;
      logic line;
      logic oe;
   } asi_core_st_t;
   asi_core_st_t s;
   asi_core_st_t n;
   logic tx_tick;
   logic rx_tick;
   logic fifo_valid;
   logic [7:0] fifo_data;
   logic pop;
   logic rise;
   logic end_fr;
   logic done;
   logic idle_ev;
   logic v;
   logic noisy;
   logic msb;
   logic par_bad;
   logic wake;
   logic [3:0] len;
   logic [3:0] pre_lim;
   logic [8:0] w9;
   logic [8:0] word;

   assign status = s.st;
   assign rx_data = s.rbuf;
   assign rx_ninth_bit = s.r9;
   assign rx_mute = s.mute;
   assign irq = s.irq;
   assign serial_out_pin = s.line;
   assign serial_out_oe = s.oe;

   // One divider per direction shares the common prescaler tick
   asi_rate u_tx_rate (
      .clk(clk),
      .reset(reset),
      .pre_tick(s.pre_tick),
      .div_sel(rate.tx_rate_div_sel),
      .fine(rate.tx_fine_prescaler),
      .tick(tx_tick)
   );
   asi_rate u_rx_rate (
      .clk(clk),
      .reset(reset),
      .pre_tick(s.pre_tick),
      .div_sel(rate.rx_rate_div_sel),
      .fine(rate.rx_fine_prescaler),
      .tick(rx_tick)
   );

   // A pop from the FIFO acts as the data-register write
   asi_fifo u_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(tx_in_valid),
      .in_data(tx_in_data),
      .in_ready(tx_in_ready),
      .out_valid(fifo_valid),
      .out_data(fifo_data),
      .out_ready(pop)
   );

   // Common prescaler limit
   always_comb begin
      case (rate.common_prescale_sel)
         2'b00: pre_lim = `ASI_PR_1;
         2'b01: pre_lim = `ASI_PR_3;
         2'b10: pre_lim = `ASI_PR_4;
         default: pre_lim = `ASI_PR_13;
      endcase
   end

   // Whole next-state: clears come first so that sets win
   always_comb begin
      n = s;
      end_fr = 1'b0;
      done = 1'b0;
      idle_ev = 1'b0;
      len = ctrl.word9 ? `ASI_LEN9 : `ASI_LEN8;
      rise = ctrl.tx_on && !s.ton_d;
      pop = fifo_valid && s.st.tx_buffer_empty_flag && s.armed && ctrl.tx_on;
      v = (s.smp_a & s.smp_b) | (s.smp_a & serial_in_pin) | (s.smp_b & serial_in_pin);
      noisy = !((s.smp_a == s.smp_b) && (s.smp_b == serial_in_pin));
      word = ctrl.word9 ? s.rsh : {1'b0, s.rsh[8:1]};
      msb = ctrl.word9 ? word[8] : word[7];
      par_bad = ctrl.parity_on && ((ctrl.word9 ? ^word : ^word[7:0]) != ctrl.parity_odd_sel);
      wake = s.mute && ctrl.wake_addr && msb;
      w9 = {tx_ninth_bit, s.thold};
      if (ctrl.parity_on) begin
         if (ctrl.word9) begin
            w9[8] = ^w9[7:0] ^ ctrl.parity_odd_sel;
         end else begin
            w9[7] = ^w9[6:0] ^ ctrl.parity_odd_sel;
         end
      end
      // Common prescaler
      n.pre_tick = 1'b0;
      n.pre = s.pre + 4'h1;
      if (s.pre >= pre_lim) begin
         n.pre = 4'h0;
         n.pre_tick = 1'b1;
      end
      // Two-step clear sequences
      if (status_access) begin
         n.armed = 1'b1;
      end
      if (pop) begin
         n.thold = fifo_data;
         n.st.tx_buffer_empty_flag = 1'b0;
         n.st.tx_done_flag = 1'b0;
         n.armed = 1'b0;
      end
      if (data_read && s.armed) begin
         n.st.rx_full_flag = 1'b0;
         n.st.idle_flag = 1'b0;
         n.st.overrun_flag = 1'b0;
         n.st.noise_flag = 1'b0;
         n.st.framing_flag = 1'b0;
         n.st.parity_fail_flag = 1'b0;
         n.armed = 1'b0;
      end
      // Transmit enable edge: idle frame queued, held byte dropped unless in TX_OFF
      n.ton_d = ctrl.tx_on;
      if (rise) begin
         n.pend_idle = 1'b1;
         if (s.txs != TX_OFF) begin
            n.st.tx_buffer_empty_flag = 1'b1;
         end
      end
      // Shift out, 16 sub-bit ticks per bit
      if (s.txs == TX_SEND && tx_tick) begin
         n.tsub = s.tsub + 4'h1;
         if (s.tsub == `ASI_SUB_LAST) begin
            n.tsh = {1'b1, s.tsh[10:1]};
            n.tbits = s.tbits - 4'h1;
            end_fr = (s.tbits == 4'h1);
         end
      end
      if (end_fr && s.kind == K_DATA) begin
         n.st.tx_done_flag = 1'b1;
      end
      if (s.txs == TX_OFF && ctrl.tx_on) begin
         n.txs = TX_WAIT;
      end
      // Choose the next frame once the line is free
      if (s.txs == TX_WAIT || end_fr) begin
         n.txs = TX_SEND;
         n.tsub = 4'h0;
         n.tbits = len;
         if (!ctrl.tx_on) begin
            n.txs = TX_OFF;
         end else if (ctrl.send_break_bit) begin
            n.tsh = '0;
            n.kind = K_BRK;
            n.brk_sent = 1'b1;
         end else if (s.brk_sent) begin
            n.tsh = '1;
            n.tbits = 4'h1;
            n.kind = K_MARK;
            n.brk_sent = 1'b0;
         end else if (n.pend_idle) begin
            n.tsh = '1;
            n.kind = K_IDLE;
            n.pend_idle = 1'b0;
         end else if (!s.st.tx_buffer_empty_flag) begin
            n.tsh = ctrl.word9 ? {1'b1, w9, 1'b0} : {2'b11, w9[7:0], 1'b0};
            n.kind = K_DATA;
            n.st.tx_buffer_empty_flag = 1'b1;
         end else begin
            n.txs = TX_WAIT;
         end
      end
      // Receive bit engine
      case (s.rxs)
         RX_OFF: begin
            n.idle_cnt = 8'h00;
            if (ctrl.rx_on) begin
               n.rxs = RX_HUNT;
            end
         end
         RX_HUNT: begin
            if (rx_tick) begin
               if (!serial_in_pin) begin
                  n.rxs = RX_BITS;
                  n.rsub = 4'h0;
                  n.rbits = 4'h0;
                  n.nz = 1'b0;
                  n.idle_cnt = 8'h00;
               end else if (s.idle_cnt != {len, 4'h0}) begin
                  n.idle_cnt = s.idle_cnt + 8'h01;
                  idle_ev = (n.idle_cnt == {len, 4'h0});
               end
            end
         end
         RX_BITS: begin
            if (rx_tick) begin
               n.rsub = s.rsub + 4'h1;
               if (s.rsub == `ASI_SMP_A) begin
                  n.smp_a = serial_in_pin;
               end
               if (s.rsub == `ASI_SMP_B) begin
                  n.smp_b = serial_in_pin;
               end
               if (s.rsub == `ASI_SMP_C) begin
                  n.nz = s.nz | noisy;
                  n.rbits = s.rbits + 4'h1;
                  if (s.rbits == 4'h0 && v) begin
                     n.rxs = RX_HUNT;
                  end else if (s.rbits == len - 4'h1) begin
                     done = 1'b1;
                     n.rxs = RX_HUNT;
                  end else if (s.rbits != 4'h0) begin
                     n.rsh = {v, s.rsh[8:1]};
                  end
               end
            end
         end
         default: begin
            n.rxs = RX_OFF;
         end
      endcase
      if (!ctrl.rx_on) begin
         n.rxs = RX_OFF;
      end
      // Completed word; muted receiver keeps flags still
      if (done && (!s.mute || wake)) begin
         if (wake) begin
            n.mute = 1'b0;
         end
         if (n.st.rx_full_flag) begin
            n.st.overrun_flag = 1'b1;
         end else begin
            n.st.rx_full_flag = 1'b1;
            n.rbuf = word[7:0];
            n.r9 = word[8];
            n.st.noise_flag = s.nz | noisy;
            n.st.framing_flag = !v;
            n.st.parity_fail_flag = par_bad;
            n.idle_armed = 1'b1;
         end
      end
      // Idle frame: wake or flag, flag only once per received word
      if (idle_ev) begin
         if (s.mute) begin
            if (!ctrl.wake_addr) begin
               n.mute = 1'b0;
            end
         end else if (s.idle_armed) begin
            n.st.idle_flag = 1'b1;
            n.idle_armed = 1'b0;
         end
      end
      // Software mute write wins over a wake in the same cycle
      if (mute_set) begin
         n.mute = 1'b1;
      end
      // Shared interrupt line; receive sources gated by mute
      n.irq = !cpu_irq_mask && (
         (ctrl.txe_irq_on && n.st.tx_buffer_empty_flag) ||
         (ctrl.txdone_irq_on && n.st.tx_done_flag) ||
         (!n.mute && ctrl.rx_irq_on && (n.st.rx_full_flag || n.st.overrun_flag)) ||
         (!n.mute && ctrl.idle_irq_on && n.st.idle_flag) ||
         (!n.mute && ctrl.parity_irq_on && n.st.parity_fail_flag));
      n.line = (n.txs == TX_SEND) ? n.tsh[0] : 1'b1;
      n.oe = ctrl.tx_on || ctrl.rx_on;
      if (reset) begin
         n = '0;
         n.st = `ASI_STAT_RST;
         n.line = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      s <= n;
   end

   // ==================================================
   // Checks
   a_tx_flags_clear: assert property (@(posedge clk) disable iff (reset)
      (pop && !end_fr && !rise) |=> (!status.tx_buffer_empty_flag && !status.tx_done_flag))
      else $error("flags not cleared by write");
   a_break_low: assert property (@(posedge clk) disable iff (reset)
      (s.txs == TX_SEND && s.kind == K_BRK) |-> !serial_out_pin)
      else $error("break frame not low");
   a_break_mark: assert property (@(posedge clk) disable iff (reset)
      (end_fr && s.kind == K_BRK && ctrl.tx_on && !ctrl.send_break_bit)
      |=> (s.kind == K_MARK && serial_out_pin))
      else $error("no mark after break");
   a_idle_first: assert property (@(posedge clk) disable iff (reset)
      ($rose(ctrl.tx_on) && s.txs == TX_OFF && !s.brk_sent && !ctrl.send_break_bit
      ##1 !ctrl.send_break_bit) |=> (s.txs == TX_SEND && s.kind == K_IDLE))
      else $error("no idle frame first");
   a_rx_full_set: assert property (@(posedge clk) disable iff (reset)
      (done && !s.mute && !s.st.rx_full_flag) |=> status.rx_full_flag)
      else $error("full flag not set");
   a_overrun_keep: assert property (@(posedge clk) disable iff (reset)
      (done && !s.mute && s.st.rx_full_flag && !(data_read && s.armed))
      |=> (status.overrun_flag && $stable(rx_data)))
      else $error("overrun handling wrong");
   a_mute_quiet: assert property (@(posedge clk) disable iff (reset)
      (done && s.mute && !wake && !data_read)
      |=> $stable({status.rx_full_flag, status.overrun_flag, status.parity_fail_flag}))
      else $error("muted receiver set a flag");
   a_idle_wake: assert property (@(posedge clk) disable iff (reset)
      (idle_ev && s.mute && !ctrl.wake_addr && !mute_set)
      |=> (!rx_mute && !$rose(status.idle_flag)))
      else $error("idle wake wrong");
   a_parity_flag: assert property (@(posedge clk) disable iff (reset)
      (done && !s.mute && !s.st.rx_full_flag && par_bad) |=> status.parity_fail_flag)
      else $error("parity error missed");
   a_irq_masked: assert property (@(posedge clk) disable iff (reset)
      cpu_irq_mask |=> !irq)
      else $error("interrupt while masked");
endmodule

// ===== asi_params.svh
// Constants of the asynchronous serial interface
`ifndef ASI_PARAMS_SVH
`define ASI_PARAMS_SVH
`define ASI_STAT_RST 8'hc0
`define ASI_SUB_LAST 4'hf
`define ASI_SMP_A 4'h7
`define ASI_SMP_B 4'h8
`define ASI_SMP_C 4'h9
`define ASI_LEN8 4'ha
`define ASI_LEN9 4'hb
`define ASI_PR_1 4'h0
`define ASI_PR_3 4'h2
`define ASI_PR_4 4'h3
`define ASI_PR_13 4'hc
`define ASI_WORD_W 8
`define ASI_FIFO_DEPTH 16
`endif

// ===== asi_pkg.sv
// Types of the asynchronous serial interface
package asi_pkg;
   typedef struct packed {
      logic tx_buffer_empty_flag;
      logic tx_done_flag;
      logic rx_full_flag;
      logic idle_flag;
      logic overrun_flag;
      logic noise_flag;
      logic framing_flag;
      logic parity_fail_flag;
   } asi_stat_t;
   typedef struct packed {
      logic [1:0] common_prescale_sel;
      logic [2:0] tx_rate_div_sel;
      logic [2:0] rx_rate_div_sel;
      logic [7:0] tx_fine_prescaler;
      logic [7:0] rx_fine_prescaler;
   } asi_rate_t;
   typedef struct packed {
      logic tx_on;
      logic rx_on;
      logic word9;
      logic send_break_bit;
      logic wake_addr;
      logic parity_on;
      logic parity_odd_sel;
      logic txe_irq_on;
      logic txdone_irq_on;
      logic rx_irq_on;
      logic idle_irq_on;
      logic parity_irq_on;
   } asi_ctrl_t;
   typedef enum logic [1:0] {TX_OFF, TX_WAIT, TX_SEND} asi_txst_t;
   typedef enum logic [1:0] {K_DATA, K_IDLE, K_BRK, K_MARK} asi_kind_t;
   typedef enum logic [1:0] {RX_OFF, RX_HUNT, RX_BITS} asi_rxst_t;
   typedef struct packed {
      logic [6:0] div;
      logic [7:0] fn;
      logic tick;
   } asi_rate_st_t;
endpackage

// ===== asi_peer.sv
// Far-side serial device model: frame sender and frame catcher
`timescale 1ns/1ps
module asi_peer #(
   parameter int BIT = 16
) (
   input wire logic clk,
   input wire logic line_in,
   input wire logic word9,
   output logic line_out
);
   logic [9:0] got_q[$];

   // Line rests at mark level between frames, as a pulled-up receive line would
   initial begin
      line_out = 1'b1;
   end

   // ==========
   // Sends one frame at falling edges: start, data LSB first, chosen stop level
   task automatic send(input logic [8:0] w, input logic stp);
      int n;
      n = word9 ? 10 : 9;
      for (int i = 0; i <= n; i++) begin
         line_out = (i == 0) ? 1'b0 : ((i == n) ? stp : w[i-1]);
         repeat (BIT) @(negedge clk);
      end
      line_out = 1'b1;
   endtask

   // ==========
   // Inverts the line for one clock after the given count of falling edges
   task automatic flip(input int at);
      repeat (at) @(negedge clk);
      line_out = ~line_out;
      @(negedge clk);
      line_out = ~line_out;
   endtask

   // ==========
   // Catches frames mid-bit; the stop bit lands just above the data bits
   always begin
      logic [9:0] f;
      @(negedge line_in);
      repeat (BIT / 2) @(posedge clk);
      f = '0;
      for (int i = 0; i < (word9 ? 10 : 9); i++) begin
         repeat (BIT) @(posedge clk);
         f[i] = line_in;
      end
      got_q.push_back(f);
   end
endmodule

// ===== asi_core_tb_top.sv
// Self-checking bench of the serial interface core
`timescale 1ns/1ps
module asi_core_tb_top;
   import asi_pkg::*;
   logic clk, reset, tx_ninth_bit, cpu_irq_mask, mute_set, status_access, data_read;
   logic tx_in_valid, tx_in_ready, sin, sout, soe, rx_ninth_bit, rx_mute, irq;
   logic [7:0] tx_in_data, rx_data, w;
   logic [9:0] f;
   logic [31:0] seed;
   asi_ctrl_t ctrl;
   asi_rate_t rate;
   asi_stat_t status;
   int err_total, check_count, n;
   logic [7:0] exp_q[$];

   asi_core asi_core_i (.clk, .reset, .ctrl, .rate, .tx_ninth_bit, .cpu_irq_mask,
      .mute_set, .status_access, .data_read, .tx_in_valid, .tx_in_data, .tx_in_ready,
      .serial_in_pin(sin), .serial_out_pin(sout), .serial_out_oe(soe), .status,
      .rx_data, .rx_ninth_bit, .rx_mute, .irq);
   asi_peer asi_peer_i (.clk(clk), .line_in(sout), .word9(ctrl.word9), .line_out(sin));

   // ==========
   // Helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
   endfunction
   task automatic rnd();
      seed = lfsr(seed);
      w = seed[7:0];
   endtask
   task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask
   task automatic hang();
      err_total++;
      final_report();
   endtask
   task automatic wait_st(input int b, input logic v);
      for (int k = 0; k < 4000 && status[b] !== v; k++) cyc(1);
      if (status[b] !== v) hang();
   endtask
   // Status access, optional data read; one spare cycle lets the flags land
   task automatic arm(input logic rd);
      status_access = 1'b1;
      cyc(1);
      status_access = 1'b0;
      data_read = rd;
      cyc(1);
      data_read = 1'b0;
      cyc(1);
   endtask
   task automatic push(input logic [7:0] d);
      tx_in_valid = 1'b1;
      tx_in_data = d;
      cyc(1);
      tx_in_valid = 1'b0;
   endtask
   task automatic take();
      for (int k = 0; k < 4000 && asi_peer_i.got_q.size() == 0; k++) cyc(1);
      if (asi_peer_i.got_q.size() == 0) hang();
      f = asi_peer_i.got_q.pop_front();
   endtask
   task automatic rx(input logic [8:0] d, input logic stp);
      asi_peer_i.send(d, stp);
      cyc(3);
   endtask

   // Free-running 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ==========
   // Main sequence
   initial begin
      {reset, tx_ninth_bit, cpu_irq_mask, mute_set, status_access, data_read} = 6'h20;
      tx_in_valid = 1'b0;
      tx_in_data = 8'h00;
      ctrl = '0;
      rate = '0;
      seed = 32'h43c3db5b;
      err_total = 0;
      check_count = 0;
      cyc(20);
      reset = 1'b0;
      chk("status", 10'h0c0, status);
      chk("pin and enable", 10'h1, {soe, sout});
      // Fill the FIFO while the transmitter is off, so it must refuse the tail
      tx_in_valid = 1'b1;
      for (int i = 0; i < 18; i++) begin
         rnd();
         tx_in_data = w;
         if (tx_in_ready === 1'b1) exp_q.push_back(w);
         cyc(1);
      end
      tx_in_valid = 1'b0;
      chk("fifo words", 10'd16, exp_q.size());
      chk("fifo ready", 10'h0, tx_in_ready);
      ctrl.tx_on = 1'b1;
      arm(1'b0);
      for (n = 3; n < 600 && sout !== 1'b0; n++) cyc(1);
      chk("idle lead", 10'h1, n >= 160 && n < 600);
      chk("output enable", 10'h1, soe);
      for (int i = 1; i < 16; i++) begin
         wait_st(7, 1'b1);
         arm(1'b0);
         wait_st(7, 1'b0);
      end
      foreach (exp_q[i]) begin
         take();
         chk("tx word", {2'b01, exp_q[i]}, f);
      end
      // Parity replaces the top bit; a write clears the done flag
      wait_st(6, 1'b1);
      rnd();
      ctrl.parity_on = 1'b1;
      ctrl.parity_odd_sel = seed[9];
      push(w);
      arm(1'b0);
      chk("tx done", 10'h0, status.tx_done_flag);
      take();
      chk("parity word", {2'b01, ^w[6:0] ^ seed[9], w[6:0]}, f);
      // Break frames repeat until released, then the line returns to mark
      ctrl.parity_on = 1'b0;
      ctrl.send_break_bit = 1'b1;
      take();
      chk("break frame", 10'h0, f);
      cyc(160);
      chk("break held", 10'h0, sout);
      ctrl.send_break_bit = 1'b0;
      for (n = 0; n < 400 && sout !== 1'b1; n++) cyc(1);
      cyc(200);
      chk("mark after break", 10'h1, sout);
      // Enable toggled while a byte waits: frame ends, idle follows, held byte is lost
      push(8'h55);
      arm(1'b0);
      cyc(20);
      push(8'haa);
      arm(1'b0);
      ctrl.tx_on = 1'b0;
      cyc(1);
      ctrl.tx_on = 1'b1;
      take();
      chk("frame before idle", 10'h155, f);
      cyc(400);
      chk("held byte dropped", 10'h0, asi_peer_i.got_q.size());
      chk("buffer empty", 10'h1, status.tx_buffer_empty_flag);
      // Slower rate: prescale 3, divide by 2, fine divide by 3 gives 288 clocks
      ctrl.tx_on = 1'b0;
      cyc(2);
      rate.common_prescale_sel = 2'b01;
      rate.tx_rate_div_sel = 3'd1;
      rate.tx_fine_prescaler = 8'd3;
      ctrl.tx_on = 1'b1;
      push(8'h01);
      arm(1'b0);
      for (n = 0; n < 7000 && sout !== 1'b0; n++) cyc(1);
      for (n = 0; n < 400 && sout === 1'b0; n++) cyc(1);
      chk("start bit length", 10'd288, n);
      wait_st(6, 1'b1);
      ctrl.tx_on = 1'b0;
      cyc(2);
      rate = '0;
      cyc(200);
      asi_peer_i.got_q.delete();
      // ==========
      // Receive: words with masking, overrun, framing, parity, ninth bit, idle
      ctrl.rx_on = 1'b1;
      ctrl.rx_irq_on = 1'b1;
      cyc(20);
      for (int i = 0; i < 4; i++) begin
         rnd();
         cpu_irq_mask = seed[8];
         rx({1'b0, w}, 1'b1);
         chk("rx data", w, rx_data);
         chk("rx full irq", {!seed[8], 1'b1}, {irq, status.rx_full_flag});
         arm(1'b1);
         chk("rx cleared", 10'h0, status.rx_full_flag);
      end
      cpu_irq_mask = 1'b0;
      rnd();
      rx({1'b0, w}, 1'b1);
      rx(9'h05a, 1'b1);
      chk("overrun", {w, 2'b11}, {rx_data, status.rx_full_flag, status.overrun_flag});
      arm(1'b1);
      chk("overrun cleared", 10'h0, status[5:3]);
      rnd();
      rx({1'b0, w}, 1'b0);
      chk("framing", {w, 2'b11}, {rx_data, status.rx_full_flag, status.framing_flag});
      arm(1'b1);
      // One-clock glitch inside a data bit: the vote keeps the bit, noise is flagged
      rnd();
      fork
         rx({1'b0, w}, 1'b1);
         asi_peer_i.flip(57);
      join
      chk("noise", {w, 2'b11}, {rx_data, status.rx_full_flag, status.noise_flag});
      arm(1'b1);
      ctrl.parity_on = 1'b1;
      ctrl.parity_irq_on = 1'b1;
      ctrl.rx_irq_on = 1'b0;
      for (int i = 0; i < 2; i++) begin
         rnd();
         w[7] = ^w[6:0] ^ ctrl.parity_odd_sel ^ i[0];
         rx({1'b0, w}, 1'b1);
         chk("parity fail irq", {2{i[0]}}, {status.parity_fail_flag, irq});
         arm(1'b1);
      end
      ctrl.parity_on = 1'b0;
      ctrl.word9 = 1'b1;
      ctrl.idle_irq_on = 1'b1;
      rnd();
      rx({1'b1, w}, 1'b1);
      chk("ninth bit", {1'b1, w}, {rx_ninth_bit, rx_data});
      arm(1'b1);
      cyc(250);
      chk("idle irq", 10'h3, {status.idle_flag, irq});
      arm(1'b1);
      ctrl.word9 = 1'b0;
      ctrl.idle_irq_on = 1'b0;
      // Muted receiver ignores plain words and wakes on an address mark
      ctrl.wake_addr = 1'b1;
      ctrl.rx_irq_on = 1'b1;
      mute_set = 1'b1;
      cyc(1);
      mute_set = 1'b0;
      rx(9'h035, 1'b1);
      chk("muted", 10'h080, {rx_mute, status[5:0], irq});
      rx(9'h0b5, 1'b1);
      chk("woken", 10'h1b5, {rx_mute, status.rx_full_flag, rx_data});
      // Idle-line wake: a full idle frame unmutes without raising the idle flag
      arm(1'b1);
      ctrl.wake_addr = 1'b0;
      mute_set = 1'b1;
      cyc(1);
      mute_set = 1'b0;
      cyc(200);
      chk("idle wake", 10'h0, {rx_mute, status.idle_flag});
      final_report();
   end
endmodule
